// [verilog/rsr_top.sv]
/*
 * Reset source recorder: merges the reset sources, sequences the internal
 * reset, records the cause and applies per-source register initialisation.
 * Assumes synchronous request inputs and an AXI4-Lite master on sys_clk.
 */
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module rsr_top #(
   parameter int STAB_LEN = rsr_pkg::STAB_CYCLES
) (
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   ce,
   input  wire rsr_pkg::rsr_src_t      src,
   input  wire logic                   standby,
   output logic                        core_reset_q,
   output logic                        mem_keep_q,
   output logic                        wdt_reset_q,
   output logic                        lv_enable_q,
   output logic                        lv_mode_q,
   output rsr_pkg::rsr_irq_bank_t      irq_bank_q,
   output logic                        irq_q,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready
);
   import rsr_pkg::*;

   localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_LEN - 1);

   rsr_seq_t         seq_q;
   rsr_cause_t       cause_q;
   rsr_cause_t       pick;
   logic [CNT_W-1:0] cnt_q;
   logic [7:0]       flags_q;
   logic [7:0]       flags_d;
   logic [EV_W-1:0]  evst_q;
   logic [EV_W-1:0]  evmask_q;
   logic [EV_W-1:0]  ev;
   logic             src_ext;
   logic             src_poc;
   logic             src_wdt;
   logic             src_lvr;
   logic             any_src;
   logic             ack;
   logic             wr_en;
   logic             rd_en;
   logic             rd_flags;
   logic             wr_hit;
   logic             rd_hit;
   logic [31:0]      rd_mux;

   // Merge byte lanes of a write into an old word
   function automatic logic [31:0] wmerge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = dat[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Higher number wins when two causes meet in the hold state of one reset
   function automatic rsr_cause_t stronger(input rsr_cause_t a, input rsr_cause_t b);
      return (a > b) ? a : b;
   endfunction

   // Request decoding; the low-voltage reset only when enabled in reset mode
   assign src_ext = ~src.ext_rst_n;
   assign src_poc = src.poc_low;
   assign src_wdt = src.wdt_ovf;
   assign src_lvr = src.lv_below & lv_enable_q & lv_mode_q;
   assign any_src = src_ext | src_poc | src_wdt | src_lvr;

   // Fixed priority when sources arrive together: power-on beats pin beats others
   always_comb begin
      if (src_poc) begin
         pick = CAUSE_POC;
      end else if (src_ext) begin
         pick = CAUSE_EXT;
      end else if (src_wdt) begin
         pick = CAUSE_WDT;
      end else if (src_lvr) begin
         pick = CAUSE_LOWV;
      end else begin
         pick = CAUSE_NONE;
      end
   end

   // Acknowledgment: the first cycle in hold with no request left; initial values land here
   assign ack = ce & (seq_q == SQ_HOLD) & ~any_src;

   // Reset sequencer: hold while requested, then stabilization wait
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         seq_q        <= SQ_WAIT;
         cnt_q        <= '0;
         cause_q      <= CAUSE_NONE;
         core_reset_q <= 1'b1;
      end else if (ce) begin
         case (seq_q)
            SQ_RUN: begin
               if (any_src) begin
                  seq_q        <= SQ_HOLD;
                  cause_q      <= pick;
                  core_reset_q <= 1'b1;
               end
            end
            SQ_HOLD: begin
               if (any_src) begin
                  cause_q <= stronger(cause_q, pick);
               end else begin
                  seq_q <= SQ_WAIT;
                  cnt_q <= '0;
               end
            end
            SQ_WAIT: begin
               if (any_src) begin
                  seq_q   <= SQ_HOLD;
                  cause_q <= pick;
               end else if (cnt_q == STAB_LAST) begin
                  seq_q        <= SQ_RUN;
                  core_reset_q <= 1'b0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               seq_q <= SQ_WAIT;
               cnt_q <= '0;
            end
         endcase
      end
   end

   // Memory retention tells the core whether a reset came out of standby
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mem_keep_q <= 1'b0;
      end else if (ce && seq_q == SQ_RUN && any_src) begin
         mem_keep_q <= standby;
      end
   end

   // Watchdog gets a one-cycle reset for every cause except the low-voltage one
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wdt_reset_q <= 1'b1;
      end else if (ce) begin
         wdt_reset_q <= ack & (cause_q != CAUSE_LOWV);
      end
   end

   // Cause flag byte: read clears, acknowledged watchdog and low-voltage causes set, pin and power-on clear; a set wins over the read
   always_comb begin
      flags_d = flags_q;
      if (rd_flags) begin
         flags_d = FLAGS_RST;
      end
      if (ack) begin
         case (cause_q)
            CAUSE_EXT, CAUSE_POC: flags_d = FLAGS_RST;
            CAUSE_WDT: flags_d[BIT_WD_FLAG] = 1'b1;
            CAUSE_LOWV: flags_d[BIT_LV_FLAG] = 1'b1;
            default: flags_d = flags_q;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         flags_q <= FLAGS_RST;
      end else if (ce) begin
         flags_q <= flags_d;
      end
   end

   // Low-voltage control: held through its own reset so the detector keeps running
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         lv_enable_q <= LVCTL_RST[BIT_LV_ON];
         lv_mode_q   <= LVCTL_RST[BIT_LV_MODE];
      end else if (ce) begin
         if (ack && cause_q != CAUSE_LOWV) begin
            lv_enable_q <= LVCTL_RST[BIT_LV_ON];
            lv_mode_q   <= LVCTL_RST[BIT_LV_MODE];
         end else if (wr_en && s_axi_awaddr == OFS_LVCTL && s_axi_wstrb[0]) begin
            lv_enable_q <= s_axi_wdata[BIT_LV_ON];
            lv_mode_q   <= s_axi_wdata[BIT_LV_MODE];
         end
      end
   end

   // Interrupt controller bytes take their initial values on every acknowledgment
   always_ff @(posedge sys_clk) begin
      if (srst || ack) begin
         irq_bank_q.req  <= IREQ_RST;
         irq_bank_q.mask <= IMASK_RST;
         irq_bank_q.prio <= IPRIO_RST;
         irq_bank_q.rise <= EDGE_RST;
         irq_bank_q.fall <= EDGE_RST;
      end else if (ce && wr_en) begin
         case (s_axi_awaddr)
            OFS_IREQ:  irq_bank_q.req  <= wmerge(irq_bank_q.req, s_axi_wdata, s_axi_wstrb);
            OFS_IMASK: irq_bank_q.mask <= wmerge(irq_bank_q.mask, s_axi_wdata, s_axi_wstrb);
            OFS_IPRIO: irq_bank_q.prio <= wmerge(irq_bank_q.prio, s_axi_wdata, s_axi_wstrb);
            OFS_EDGE: begin
               if (s_axi_wstrb[0]) begin
                  irq_bank_q.rise <= s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  irq_bank_q.fall <= s_axi_wdata[15:8];
               end
            end
            default: ;
         endcase
      end
   end

   // Event sources for the block's own interrupt
   always_comb begin
      ev            = '0;
      ev[EV_EXT]    = ack & (cause_q == CAUSE_EXT);
      ev[EV_POC]    = ack & (cause_q == CAUSE_POC);
      ev[EV_WDT]    = ack & (cause_q == CAUSE_WDT);
      ev[EV_LVR]    = ack & (cause_q == CAUSE_LOWV);
      ev[EV_LVINT]  = lv_enable_q & ~lv_mode_q & src.lv_below;
   end

   // Sticky status, write one to clear; an event in the clearing cycle survives.
   // Status and mask are not touched by reset acknowledgment so causes stay visible.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         evst_q   <= EVST_RST;
         evmask_q <= EVMASK_RST;
      end else if (ce) begin
         if (wr_en && s_axi_awaddr == OFS_EVST && s_axi_wstrb[0]) begin
            evst_q <= (evst_q & ~s_axi_wdata[EV_W-1:0]) | ev;
         end else begin
            evst_q <= evst_q | ev;
         end
         if (wr_en && s_axi_awaddr == OFS_EVMASK && s_axi_wstrb[0]) begin
            evmask_q <= s_axi_wdata[EV_W-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= |(evst_q & evmask_q);
      end
   end

   // Address decode shared by both directions
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         OFS_FLAGS, OFS_LVCTL, OFS_IREQ, OFS_IMASK, OFS_IPRIO,
         OFS_EDGE, OFS_EVST, OFS_EVMASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   assign wr_hit   = mapped(s_axi_awaddr);
   assign rd_hit   = mapped(s_axi_araddr);
   assign wr_en    = s_axi_awready & wr_hit;
   assign rd_en    = s_axi_arready;
   assign rd_flags = rd_en & (s_axi_araddr == OFS_FLAGS);

   // Read data; cause flags appear only as a whole byte, unused bits are zero
   always_comb begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         OFS_FLAGS:  rd_mux = {24'h000000, flags_q};
         OFS_LVCTL:  rd_mux = {24'h000000, lv_enable_q, 5'h00, lv_mode_q,
                               lv_enable_q & src.lv_below};
         OFS_IREQ:   rd_mux = irq_bank_q.req;
         OFS_IMASK:  rd_mux = irq_bank_q.mask;
         OFS_IPRIO:  rd_mux = irq_bank_q.prio;
         OFS_EDGE:   rd_mux = {16'h0000, irq_bank_q.fall, irq_bank_q.rise};
         OFS_EVST:   rd_mux = {27'h0000000, evst_q};
         OFS_EVMASK: rd_mux = {27'h0000000, evmask_q};
         default:    rd_mux = 32'h00000000;
      endcase
   end

   // Write channel: address and data taken together once both are offered
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: data registered so the read-clear and the answer share one edge
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // rsr_top

// [inc/rsr_pkg.sv]
/*
 * Package of the reset source recorder: register offsets, field positions,
 * reset values, timing counts, sequencer states and carrier structs.
 * Assumes a 125 MHz system clock and an AXI4-Lite register bus with 32-bit data.
 */
package rsr_pkg;

   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] OFS_FLAGS  = 8'h00;
   localparam logic [7:0] OFS_LVCTL  = 8'h04;
   localparam logic [7:0] OFS_IREQ   = 8'h08;
   localparam logic [7:0] OFS_IMASK  = 8'h0c;
   localparam logic [7:0] OFS_IPRIO  = 8'h10;
   localparam logic [7:0] OFS_EDGE   = 8'h14;
   localparam logic [7:0] OFS_EVST   = 8'h18;
   localparam logic [7:0] OFS_EVMASK = 8'h1c;

   // Field positions
   localparam int BIT_LV_FLAG  = 0;     // Low-voltage cause in the flag byte
   localparam int BIT_WD_FLAG  = 4;     // Watchdog cause in the flag byte
   localparam int BIT_LV_ON    = 7;     // Detector enable
   localparam int BIT_LV_MODE  = 1;     // 1: reset, 0: interrupt
   localparam int BIT_LV_DET   = 0;     // Below-threshold indication, read-only
   localparam int EV_EXT       = 0;
   localparam int EV_POC       = 1;
   localparam int EV_WDT       = 2;
   localparam int EV_LVR       = 3;
   localparam int EV_LVINT     = 4;
   localparam int EV_W         = 5;

   // Reset values
   localparam logic [7:0]      FLAGS_RST  = 8'h00;
   localparam logic [7:0]      LVCTL_RST  = 8'h00;
   localparam logic [31:0]     IREQ_RST   = 32'h00000000;
   localparam logic [31:0]     IMASK_RST  = 32'hdfffffff;
   localparam logic [31:0]     IPRIO_RST  = 32'hffffffff;
   localparam logic [7:0]      EDGE_RST   = 8'h00;
   localparam logic [EV_W-1:0] EVST_RST   = 5'h00;
   localparam logic [EV_W-1:0] EVMASK_RST = 5'h00;

   // Stabilization wait: ticks of the slow clock, slow clock as sys_clk divided
   localparam int STAB_TICKS  = 21;
   localparam int SLOW_DIV    = 8;
   localparam int STAB_CYCLES = STAB_TICKS * SLOW_DIV;
   localparam int CNT_W       = 12;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {SQ_RUN, SQ_HOLD, SQ_WAIT} rsr_seq_t;
   typedef enum logic [2:0] {CAUSE_NONE, CAUSE_LOWV, CAUSE_WDT, CAUSE_EXT, CAUSE_POC} rsr_cause_t;

   // Reset request inputs, all synchronous to sys_clk
   typedef struct packed {
      logic ext_rst_n;    // External reset pin, low active
      logic poc_low;      // Supply below power-on-clear threshold
      logic wdt_ovf;      // Watchdog overflow request
      logic lv_below;     // Supply below low-voltage threshold
   } rsr_src_t;

   // Interrupt controller byte registers, four bytes per word for req, mask and prio, single bytes for rise and fall
   typedef struct packed {
      logic [31:0] req;
      logic [31:0] mask;
      logic [31:0] prio;
      logic [7:0]  rise;
      logic [7:0]  fall;
   } rsr_irq_bank_t;

endpackage

// [bench/rsr_checker.sv]
/*
 * Checker of the reset source recorder: concurrent assertions on the top ports.
 * Assumes binding to rsr_top and a single sys_clk domain with srst.
 */
`timescale 1ns/1ps
module rsr_checker
   import rsr_pkg::*;
#(
   parameter int STAB_LEN = 4
) (
   input wire logic          sys_clk,
   input wire logic          srst,
   input wire logic          ce,
   input wire rsr_src_t      src,
   input wire logic          core_reset_q,
   input wire logic          wdt_reset_q,
   input wire logic          lv_enable_q,
   input wire logic          lv_mode_q,
   input wire rsr_irq_bank_t irq_bank_q,
   input wire logic [7:0]    s_axi_araddr,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic [31:0]   s_axi_rdata,
   input wire logic          s_axi_rvalid,
   input wire logic          s_axi_bvalid
);
   logic [7:0] rd_addr_q;
   default clocking cb @(posedge sys_clk); endclocking
   // Address of the read in flight, held because the master drops it after the handshake
   always_ff @(posedge sys_clk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_addr_q <= s_axi_araddr;
      end
   end
   AST_SRST_HOLD: assert property (srst |=> core_reset_q && !s_axi_bvalid && !s_axi_rvalid)
      else $error("core reset or bus answer wrong during srst");
   AST_SRST_BANK: assert property (srst |=> irq_bank_q ==
      {IREQ_RST, IMASK_RST, IPRIO_RST, EDGE_RST, EDGE_RST})
      else $error("interrupt bank not at initial values");
   AST_SRST_LV: assert property (srst |=> !lv_enable_q && !lv_mode_q)
      else $error("low-voltage control not cleared");
   AST_SRC_TAKE: assert property (disable iff (srst)
      ce && (src.poc_low || !src.ext_rst_n) |=> core_reset_q)
      else $error("pin or power-on request not taken");
   AST_WDT_PULSE: assert property (disable iff (srst)
      ce && wdt_reset_q && !$past(srst) |=> !wdt_reset_q)
      else $error("watchdog reset longer than one cycle");
   AST_WDT_IN_RST: assert property (wdt_reset_q |-> core_reset_q)
      else $error("watchdog reset outside core reset");
   AST_CORE_WAIT: assert property (disable iff (srst) $fell(core_reset_q) |->
      $past(src.ext_rst_n) && !$past(src.poc_low) && !$past(src.wdt_ovf))
      else $error("core reset released while a source was active");
   AST_STAB_WAIT: assert property ($fell(srst) |-> core_reset_q [*4])
      else $error("stabilization wait too short");
   AST_FLAG_BITS: assert property (s_axi_rvalid && rd_addr_q == OFS_FLAGS |->
      (s_axi_rdata & ~((32'h1 << BIT_LV_FLAG) | (32'h1 << BIT_WD_FLAG))) == 32'h0)
      else $error("cause flag word has stray bits");
   // Main scenarios
   cover property ($rose(wdt_reset_q));
   cover property (s_axi_rvalid && rd_addr_q == OFS_FLAGS && s_axi_rdata != 32'h0);
   cover property ($fell(core_reset_q) && lv_enable_q);
endmodule // rsr_checker

bind rsr_top rsr_checker #(.STAB_LEN(STAB_LEN)) chk_u (.sys_clk, .srst, .ce, .src,
   .core_reset_q, .wdt_reset_q, .lv_enable_q, .lv_mode_q, .irq_bank_q, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_bvalid);

// [bench/test_reset_source_recorder.sv]
/*
 * Self-checking bench of the reset source recorder: AXI4-Lite tasks, reset causes, events.
 * Assumes rsr_top with a short stabilization wait and a 125 MHz sys_clk.
 */
`timescale 1ns/1ps
module test_reset_source_recorder;
   import rsr_pkg::*;
   localparam rsr_src_t IDLE = 4'h8;
   localparam int PIN_HOLD = 1250;    // 10 us of 8 ns cycles, least low time of the pin
   logic sys_clk, srst, ce, standby, core_reset_q, mem_keep_q, wdt_reset_q;
   logic lv_enable_q, lv_mode_q, irq_q;
   rsr_src_t src_i;
   rsr_irq_bank_t irq_bank_q;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int errors, checks_done, cyc, np;
   logic [31:0] d;
   logic [1:0] r;
   logic [7:0] fm, lm;
   logic stb;
   int seq[8] = '{2, 3, 2, 3, 2, 0, 3, 1};
   logic [7:0] rdm = 8'had;

   rsr_top #(.STAB_LEN(4)) dut_u (.sys_clk(sys_clk), .srst(srst), .ce(ce), .src(src_i),
      .standby(standby), .core_reset_q(core_reset_q), .mem_keep_q(mem_keep_q),
      .wdt_reset_q(wdt_reset_q), .lv_enable_q(lv_enable_q), .lv_mode_q(lv_mode_q),
      .irq_bank_q(irq_bank_q), .irq_q(irq_q), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));

   // Clock, 8 ns period
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Hang guard, far above the expected run of under two thousand cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Flag byte after a reset of cause c: 0 pin, 1 power-on, 2 watchdog, 3 low-voltage
   function automatic logic [7:0] nf(input logic [7:0] f, input int c);
      case (c)
         2: nf = f | (8'h01 << BIT_WD_FLAG);
         3: nf = f | (8'h01 << BIT_LV_FLAG);
         default: nf = 8'h00;
      endcase
   endfunction

   // Write with both channels offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      logic [1:0] rs;
      rd(a, v, rs);
      chk($sformatf("read %h", a), e, v);
      chk("rresp", RESP_OKAY, rs);
   endtask

   // Raise one source for three cycles, the pin for its least low time;
   // count watchdog pulses until the core runs again
   task automatic fire(input int c, input logic sb, output int n);
      rsr_src_t s;
      s = IDLE;
      case (c)
         0: s.ext_rst_n = 1'b0;
         1: s.poc_low = 1'b1;
         2: s.wdt_ovf = 1'b1;
         default: s.lv_below = 1'b1;
      endcase
      n = 0;
      @(posedge sys_clk);
      standby <= sb;
      src_i <= s;
      repeat ((c == 0) ? PIN_HOLD : 3) @(posedge sys_clk);
      src_i <= IDLE;
      do begin
         @(posedge sys_clk);
         if (wdt_reset_q === 1'b1) n++;
      end while (core_reset_q !== 1'b0);
   endtask

   initial begin
      {srst, ce, standby, src_i} = {1'b1, 1'b1, 1'b0, IDLE};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      void'($urandom(32'he274f597));
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      do @(posedge sys_clk); while (core_reset_q !== 1'b0);
      rc(OFS_FLAGS, 32'h0);
      rc(OFS_LVCTL, 32'h0);
      rc(OFS_IREQ, IREQ_RST);
      rc(OFS_IMASK, IMASK_RST);
      rc(OFS_IPRIO, IPRIO_RST);
      rc(OFS_EDGE, {16'h0, EDGE_RST, EDGE_RST});
      rd(8'h40, d, r);
      chk("unmapped rresp", RESP_SLVERR, r);
      chk("unmapped rdata", 32'h0, d);
      wr(8'h40, 32'hffffffff, r);
      chk("unmapped bresp", RESP_SLVERR, r);
      // Random words through the three interrupt bank words
      for (int j = 0; j < 6; j++) begin
         d = $urandom;
         wr(OFS_IREQ + 8'(4 * (j % 3)), d, r);
         chk("bresp", RESP_OKAY, r);
         rc(OFS_IREQ + 8'(4 * (j % 3)), d);
      end
      fm = 8'h00;
      // Every cause, flags read only on some passes so held bits pile up
      for (int k = 0; k < 8; k++) begin
         stb = 1'($urandom_range(1, 0));
         wr(OFS_LVCTL, 32'h82, r);
         wr(OFS_IREQ, $urandom, r);
         fire(seq[k], stb, np);
         fm = nf(fm, seq[k]);
         lm = (seq[k] == 3) ? 8'h82 : 8'h00;
         chk("wdt pulses", (seq[k] != 3), np);
         chk("mem keep", stb, mem_keep_q);
         chk("req", IREQ_RST, irq_bank_q.req);
         chk("mask", IMASK_RST, irq_bank_q.mask);
         chk("prio", IPRIO_RST, irq_bank_q.prio);
         chk("edges", {EDGE_RST, EDGE_RST}, {irq_bank_q.fall, irq_bank_q.rise});
         rc(OFS_LVCTL, lm);
         if (rdm[k]) begin
            rc(OFS_FLAGS, fm);
            fm = 8'h00;
            rc(OFS_FLAGS, 32'h0);
         end
      end
      // Event interrupt: raise, mask, unmask, clear by writing one
      wr(OFS_EVST, 32'h1f, r);
      wr(OFS_EVMASK, 32'h1 << EV_WDT, r);
      fire(2, 1'b0, np);
      chk("irq set", 1'b1, irq_q);
      wr(OFS_EVMASK, 32'h0, r);
      repeat (2) @(posedge sys_clk);
      chk("irq masked", 1'b0, irq_q);
      wr(OFS_EVMASK, 32'h1 << EV_WDT, r);
      repeat (2) @(posedge sys_clk);
      chk("irq unmasked", 1'b1, irq_q);
      wr(OFS_EVST, 32'h1 << EV_WDT, r);
      repeat (2) @(posedge sys_clk);
      chk("irq cleared", 1'b0, irq_q);
      rc(OFS_EVST, 32'h0);
      // Detector in interrupt mode: no reset, live below flag, sticky status bit
      wr(OFS_LVCTL, 32'h80, r);
      src_i.lv_below <= 1'b1;
      rc(OFS_LVCTL, 32'h81);
      src_i.lv_below <= 1'b0;
      chk("no lv reset", 1'b0, core_reset_q);
      rc(OFS_EVST, 32'h1 << EV_LVINT);
      // Second power-up reset in mid-run, then a frozen clock enable in the wait
      srst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      ce <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk("ce freeze", 1'b1, core_reset_q);
      ce <= 1'b1;
      do @(posedge sys_clk); while (core_reset_q !== 1'b0);
      rc(OFS_LVCTL, 32'h0);
      rc(OFS_EVST, 32'h0);
      report_and_stop();
   end
endmodule // test_reset_source_recorder
